//--- erb_consts.vh
`ifndef ERB_CONSTS_VH
`define ERB_CONSTS_VH
// Opcode field width and codes within the frame that follows the start bit.
`define ERB_OP_W         2
`define ERB_OP_READ      2'b10
`define ERB_OP_WRITE     2'b01
`define ERB_OP_ERASE     2'b11
`define ERB_OP_EXT       2'b00
// Extended command codes, held in the two upper address bits.
`define ERB_EXT_LOCK     2'b00
`define ERB_EXT_ENABLE   2'b11
// Variant groups.
`define ERB_GRP_W        3
`define ERB_GRP_1        3'h1
`define ERB_GRP_2        3'h2
`define ERB_GRP_3        3'h3
`define ERB_GRP_4        3'h4
`define ERB_GRP_5        3'h5
// Frame states.
`define ERB_ST_W         3
`define ERB_ST_IDLE      3'h0
`define ERB_ST_OP        3'h1
`define ERB_ST_ADDR      3'h2
`define ERB_ST_DATA      3'h3
`define ERB_ST_READ      3'h4
`define ERB_ST_WAIT      3'h5
`define ERB_ST_IGNORE    3'h6
`endif

//--- erb_core.v
// Operation
// [RL1] During a write cycle with select high, data out is driven low, then high when it ends; group 1 floats once it ends.
// [RL2] Groups 1 to 3 leave data out floating when select rises after the cycle has ended; groups 2, 3 drive high if select fell during the cycle.
// [RL3] Groups 4 and 5 drive data out high when select rises after the cycle has ended.
// [RL4] Groups 4 and 5 hold that ready level until a start bit is seen, then float.
// [RL5] With select high, a clock rise sampling data in high is a start bit, even right after a write.
// [RL6] The write cycle length is variable and its end is not tied to any clock count.
// [RL7] After the enable command, an erase sets every bit of the addressed word to one.
// [RL8] The host lowers select at the end of every command.
// [RL9] The host finds write completion by polling data out, not by a fixed delay.
// [RL10] The host polling routine ends with select low.
// [RL11] The host keeps the clock still while select is high during a write cycle.
// [RL12] Groups 1, 3, 5 start the write on the last data bit edge; groups 2, 4 on select falling.
// [RL13] In group 1 after polling, select must go low then high before a next command is taken.
// [RL14] With select low and no read running, data out floats.
`timescale 1ns/100ps
`include "erb_consts.vh"
module erb_core #(
  parameter AW    = 6,                   // address bits
  parameter DW    = 16,                  // data bits
  parameter GROUP = 3'h4                 // variant group, 1 to 5
) (
  input  wire          mclk_i,           // system clock, 50 MHz
  input  wire          arst_n_i,         // asynchronous reset, active low
  input  wire          cs_i,             // chip select pin
  input  wire          sclk_i,           // serial clock pin from the host
  input  wire          sdi_i,            // serial data in pin
  output reg           sdo_o,            // serial data out level
  output reg           sdo_oe_o,         // serial data out enable, high drives
  input  wire          wr_done_i,        // write cycle finished, level from the cell array
  output reg           wr_start_o,       // one-cycle pulse starting a write cycle
  output reg  [AW-1:0] wr_addr_o,        // address of the write in progress
  output reg  [DW-1:0] wr_data_o,        // data of the write in progress
  output reg  [AW-1:0] rd_addr_o,        // address being read
  input  wire [DW-1:0] rd_data_i,        // array word at rd_addr_o
  output reg           busy_o            // write cycle in progress
);
  localparam CW = 6;
  localparam NEW_GRP = (GROUP == `ERB_GRP_4) || (GROUP == `ERB_GRP_5);
  localparam CS_STARTS = (GROUP == `ERB_GRP_2) || (GROUP == `ERB_GRP_4);
  localparam [CW-1:0] AW_LAST = AW - 1;
  localparam [CW-1:0] DW_LAST = DW - 1;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage is read only by the second.
  reg [1:0] cs_s_r, ck_s_r, di_s_r, dn_s_r;
  reg       ck_d_r, cs_d_r;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_s_r <= 2'b00;
      ck_s_r <= 2'b00;
      di_s_r <= 2'b00;
      dn_s_r <= 2'b00;
      ck_d_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[0], cs_i};
      ck_s_r <= {ck_s_r[0], sclk_i};
      di_s_r <= {di_s_r[0], sdi_i};
      dn_s_r <= {dn_s_r[0], wr_done_i};
      ck_d_r <= ck_s_r[1];
      cs_d_r <= cs_s_r[1];
    end
  end
  wire cs   = cs_s_r[1];
  wire di   = di_s_r[1];
  wire done = dn_s_r[1];
  wire ck_rise = ck_s_r[1] & ~ck_d_r;
  wire ck_fall = ~ck_s_r[1] & ck_d_r;
  wire cs_rise = cs & ~cs_d_r;
  wire cs_fall = ~cs & cs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder and write cycle tracking.
  reg [`ERB_ST_W-1:0] st_r;
  reg [`ERB_OP_W-1:0] op_r;
  reg [CW-1:0]        cnt_r;
  reg [AW-1:0]        addr_r;
  reg [DW-1:0]        data_r;
  reg [DW-1:0]        rsh_r;
  reg                 wen_r;             // erase and write enabled
  reg                 pend_r;            // write armed, waiting for select low
  reg                 busy_r;
  reg                 rdy_r;             // ready level is being driven
  reg                 poll_r;            // select was high through a busy phase
  reg                 block_r;           // commands held off until select cycles
  wire start = cs & ck_rise & di & (st_r == `ERB_ST_IDLE) & ~busy_r & ~block_r;
  wire is_erase = (op_r == `ERB_OP_ERASE);
  wire last_in = ck_rise & (st_r == `ERB_ST_DATA) & (cnt_r == DW_LAST);
  wire go_clk = ~CS_STARTS & last_in & wen_r;                           // [RL12]
  wire go_cs  = CS_STARTS & pend_r & cs_fall;                           // [RL12]
  wire addr_go = ck_rise & (st_r == `ERB_ST_ADDR) & (cnt_r == AW_LAST) & wen_r;
  wire ers_go = addr_go & is_erase;                                     // [RL7]

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= `ERB_ST_IDLE;
      op_r       <= 2'b00;
      cnt_r      <= 6'h00;
      addr_r     <= {AW{1'b0}};
      data_r     <= {DW{1'b0}};
      rsh_r      <= {DW{1'b0}};
      wen_r      <= 1'b0;
      pend_r     <= 1'b0;
      busy_r     <= 1'b0;
      rdy_r      <= 1'b0;
      poll_r     <= 1'b0;
      block_r    <= 1'b0;
      wr_start_o <= 1'b0;
      wr_addr_o  <= {AW{1'b0}};
      wr_data_o  <= {DW{1'b0}};
    end else begin
      wr_start_o <= 1'b0;
      if (!cs) begin
        st_r <= `ERB_ST_IDLE;
        rdy_r <= 1'b0;
        if (cs_fall & block_r & ~busy_r)
          block_r <= 1'b0;                                              // [RL13]
        // A finished poll must not leave a ready level for a later select rise.
        if (cs_fall & ~busy_r)
          poll_r <= 1'b0;                                               // [RL2]
      end else if (start) begin
        st_r <= `ERB_ST_OP;                                             // [RL5]
        cnt_r <= 6'h00;
        rdy_r <= 1'b0;                                                  // [RL4]
      end else if (ck_rise) begin
        case (st_r)
          `ERB_ST_OP: begin
            op_r <= {op_r[0], di};
            if (cnt_r == 6'h01) begin
              st_r <= `ERB_ST_ADDR;
              cnt_r <= 6'h00;
            end else cnt_r <= cnt_r + 6'h01;
          end
          `ERB_ST_ADDR: begin
            addr_r <= {addr_r[AW-2:0], di};
            cnt_r <= (cnt_r == AW_LAST) ? 6'h00 : cnt_r + 6'h01;
            if (cnt_r == AW_LAST) begin
              case (op_r)
                `ERB_OP_READ: st_r <= `ERB_ST_READ;
                `ERB_OP_WRITE: st_r <= `ERB_ST_DATA;
                `ERB_OP_ERASE: st_r <= `ERB_ST_WAIT;
                default: begin
                  st_r <= `ERB_ST_IGNORE;
                  if (addr_r[AW-2 -: 2] == `ERB_EXT_ENABLE) wen_r <= 1'b1;
                  if (addr_r[AW-2 -: 2] == `ERB_EXT_LOCK) wen_r <= 1'b0;
                end
              endcase
            end
          end
          `ERB_ST_DATA: begin
            data_r <= {data_r[DW-2:0], di};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == DW_LAST) st_r <= `ERB_ST_WAIT;
          end
          default: ;
        endcase
      end
      // Erase writes all ones; the array sees it as an ordinary write.
      if (ers_go | (last_in & wen_r)) begin
        wr_addr_o <= ers_go ? {addr_r[AW-2:0], di} : addr_r;
        wr_data_o <= ers_go ? {DW{1'b1}} : {data_r[DW-2:0], di};       // [RL7]
        if (CS_STARTS) pend_r <= 1'b1;
      end
      if (go_clk | go_cs | (ers_go & ~CS_STARTS)) begin
        wr_start_o <= 1'b1;
        busy_r <= 1'b1;
        pend_r <= 1'b0;
        poll_r <= 1'b0;
      end else if (busy_r & wr_start_o == 1'b0 & done) begin
        // Completion is taken whenever the array says so, never counted.
        busy_r <= 1'b0;                                                 // [RL6]
        if (GROUP == `ERB_GRP_1 && poll_r) block_r <= 1'b1;             // [RL13]
        if (NEW_GRP && cs) rdy_r <= 1'b1;                               // [RL1]
      end
      if (busy_r & cs) poll_r <= 1'b1;
      if (NEW_GRP && cs_rise && !busy_r && !pend_r && st_r == `ERB_ST_IDLE)
        rdy_r <= 1'b1;                                                  // [RL3]
      if (ck_rise & (st_r == `ERB_ST_ADDR) & (cnt_r == AW_LAST))
        rsh_r <= rd_data_i;
      else if (ck_fall & (st_r == `ERB_ST_READ))
        rsh_r <= {rsh_r[DW-2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data out. Original groups drive ready only if select was high during busy, so a late poll sees a float.
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
      rd_addr_o <= {AW{1'b0}};
      busy_o    <= 1'b0;
    end else begin
      busy_o <= busy_r;
      rd_addr_o <= addr_r;
      if (!cs) begin
        sdo_oe_o <= 1'b0;                                               // [RL14]
        sdo_o <= 1'b0;
      end else if (busy_r) begin
        sdo_oe_o <= 1'b1;                                               // [RL1]
        sdo_o <= 1'b0;
      end else if (st_r == `ERB_ST_READ) begin
        sdo_oe_o <= 1'b1;
        sdo_o <= rsh_r[DW-1];
      end else if (rdy_r | (poll_r & ~NEW_GRP & st_r == `ERB_ST_IDLE & ~block_r)) begin
        sdo_oe_o <= 1'b1;                                               // [RL1] [RL4]
        sdo_o <= 1'b1;
      end else begin
        sdo_oe_o <= 1'b0;                                               // [RL2]
        sdo_o <= 1'b0;
      end
    end
  end
endmodule // erb_core

//--- erb_core_chk.sv
`timescale 1ns/100ps
module erb_core_chk #(
  parameter GROUP = 3'h4       // variant group
) (
  input wire mclk_i,           // clock
  input wire arst_n_i,         // reset, active low
  input wire cs_i,             // select
  input wire sclk_i,           // serial clock
  input wire sdi_i,            // serial data in
  input wire sdo_o,            // data out level
  input wire sdo_oe_o,         // data out enable
  input wire wr_done_i,        // write finished
  input wire wr_start_o,       // write launch pulse
  input wire busy_o            // write in progress
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Ready after select rises only means something once a write has been launched.
  reg wrote_r;
  always @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i) wrote_r <= 1'b0;
    else if (wr_start_o) wrote_r <= 1'b1;
  sequence s_done_polled; cs_i && busy_o && $rose(wr_done_i); endsequence
  // A launch pulse still standing means busy is about to rise, so it is not an idle select.
  sequence s_idle_select;
    GROUP >= 4 && wrote_r && !busy_o && !wr_start_o && $rose(cs_i);
  endsequence
  property p_float; !cs_i [*4] |-> !sdo_oe_o; endproperty
  a_float: assert property (p_float) else $error("data out driven with select low");
  property p_busy_low; (cs_i && busy_o && !wr_done_i) [*5] |-> sdo_oe_o && !sdo_o; endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy level not low");
  property p_ready; s_done_polled |-> ##[2:6] (sdo_oe_o && sdo_o); endproperty
  a_ready: assert property (p_ready) else $error("ready level missing");
  property p_ready_new; s_idle_select |-> ##[3:5] (sdo_oe_o && sdo_o); endproperty
  a_ready_new: assert property (p_ready_new) else $error("no ready on select rise");
  property p_start_bit;
    $rose(sclk_i) && sdi_i && cs_i && !busy_o && sdo_oe_o && sdo_o |-> ##[1:6] !sdo_oe_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("ready kept after start");
  property p_launch; wr_start_o |-> (GROUP % 2 == 1 || !cs_i) ##1 busy_o && !wr_start_o; endproperty
  a_launch: assert property (p_launch) else $error("bad write launch");
  property p_hold; (busy_o && !wr_done_i) [*4] |=> busy_o; endproperty
  a_hold: assert property (p_hold) else $error("busy ended without done");
  property p_end; $rose(wr_done_i) && busy_o |-> ##[2:6] !busy_o; endproperty
  a_end: assert property (p_end) else $error("busy stuck after done");
endmodule // erb_core_chk
bind erb_core erb_core_chk #(.GROUP(GROUP)) erb_core_chk_i (.*);

//--- erb_host.sv
`timescale 1ns/100ps
module erb_host (
  input  wire  mclk_i,         // bench clock
  output logic cs_o,           // select
  output logic sclk_o,         // serial clock, still between frames
  output logic sdi_o,          // serial data to the device
  input  wire  sdo_i,          // serial data from the device
  input  wire  sdo_oe_i        // device drives data out
);
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic frame(input logic [31:0] b, input int n, input bit keep);
    cs_o <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= b[i];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b0;
    end
    sdi_o <= ~sdi_o;
    if (!keep) cs_o <= 1'b0;
  endtask
  task automatic release_cs();
    cs_o <= 1'b0;
  endtask
  // Clock stays still while polling so no stray start bit is taken.
  task automatic poll(input int lim, output bit ok);
    ok = 1'b0;
    cs_o <= 1'b1;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge mclk_i);
      ok = (sdo_oe_i === 1'b1) && (sdo_i === 1'b1);
    end
    cs_o <= 1'b0;
  endtask
endmodule // erb_host

//--- erb_core_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module erb_core_tb;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wr_done_i = 1'b0;
  logic [15:0] rd_data_i = 16'h0000;
  wire         cs_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, wr_start_o, busy_o;
  wire  [5:0]  wr_addr_o, rd_addr_o;
  wire  [15:0] wr_data_o;
  int          err_total = 0;
  int          comparisons = 0;
  erb_core erb_core_i (.*);
  erb_host erb_host_i (.mclk_i(mclk_i), .cs_o(cs_i), .sclk_o(sclk_i), .sdi_o(sdi_i),
                       .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));
  initial forever #10 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic run_write(input logic [31:0] b, input int n, input logic [5:0] a,
                           input logic [15:0] d);
    int k;
    bit ok;
    erb_host_i.frame(b, n, 1'b0);
    for (k = 0; k < 20 && wr_start_o !== 1'b1; k++) @(negedge mclk_i);
    `CHK("launch", 1'b1, wr_start_o)
    `CHK("addr", a, wr_addr_o)
    `CHK("data", d, wr_data_o)
    fork
      begin
        repeat (15) @(negedge mclk_i);
        `CHK("busy level", 2'b10, {sdo_oe_o, sdo_o})
        wr_done_i <= 1'b1;
      end
      erb_host_i.poll(60, ok);
    join
    `CHK("poll ready", 1'b1, ok)
    for (k = 0; k < 20 && busy_o !== 1'b0; k++) @(negedge mclk_i);
    `CHK("busy end", 1'b0, busy_o)
    wr_done_i <= 1'b0;
    repeat (6) @(negedge mclk_i);
    `CHK("float", 1'b0, sdo_oe_o)
  endtask
  task automatic ready_then_start();
    fork
      erb_host_i.frame(32'h1, 1, 1'b1);
      begin
        repeat (5) @(negedge mclk_i);
        `CHK("ready", 2'b11, {sdo_oe_o, sdo_o})
      end
    join
    repeat (4) @(negedge mclk_i);
    `CHK("float start", 1'b0, sdo_oe_o)
    erb_host_i.release_cs();
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    erb_host_i.frame(32'h130, 9, 1'b0);
    repeat (4) @(posedge mclk_i);
    run_write({7'd0, 1'b1, 2'b01, 6'h15, 16'hA5C3}, 25, 6'h15, 16'hA5C3);
    ready_then_start();
    run_write({23'd0, 1'b1, 2'b11, 6'h3F}, 9, 6'h3F, 16'hFFFF);
    print_verdict();
  end
endmodule // erb_core_tb
